// ### epa_arbiter.sv
/*
 exception priority arbiter: picks one exception per cycle.
 assumes pipeline status inputs are synchronous and hold while true.
*/
//
// Function
// - hard reset or test reset wins always, taken at once.
// - machine check outranks all but hard reset, taken at once.
// - machine check sources are parity errors, tea and mcp, when enabled.
// - disabled machine check condition enters checkstop, no exception.
// - soft reset is third, taken when recoverable.
// - maskable order: sys mgmt, external, perf mon, decrementer, thermal.
// - decrementer fires passing zero; perf and thermal chosen by software.
// - maskable waits for next instruction to complete, then halts completion.
// - maskable taken only in recoverable state.
// - recoverable needs drained store queue and signalled completion done.
// - recoverable flag zero means nonrecoverable.
// - completion means registers updated then retired from buffer.
// - fetch fault stops dispatch, drains; draining faults win.
// - dispatch or execution fault waits for older completion.
// - completion fault wins and discards pending instruction fault.
// - trace follows completion unless another exception occurred.
// - hard reset and machine check never wait for precise handling; soft reset waits for recoverable state.
// - precise instruction exceptions go in program order.
// - no imprecise exception class exists.
// - external request needs async enable and input asserted.
// - decrementer latches on msb rising at any async enable; taken while async enable is one.
module epa_arbiter
  import epa_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      sys_rst_i,
  // reset pins
  input  wire logic                      hard_reset_in_i,
  input  wire logic                      test_reset_i,
  input  wire logic                      soft_reset_in_i,
  // machine check sources
  input  wire logic                      l1_addr_par_err_i,
  input  wire logic                      l1_data_par_err_i,
  input  wire logic                      l2_data_par_err_i,
  input  wire logic                      transfer_error_ack_i,
  input  wire logic                      machine_check_in_i,
  input  wire logic                      mcheck_enable_i,
  // maskable sources
  input  wire logic                      sys_mgmt_req_i,
  input  wire logic                      ext_req_i,
  input  wire logic                      perf_mon_event_i,
  input  wire logic                      thermal_event_i,
  input  wire logic [`EPA_DCNT_WIDTH-1:0] down_counter_i,
  // machine state
  input  wire logic                      async_enable_flag_i,
  input  wire logic                      recoverable_flag_i,
  input  wire logic                      trace_enable_i,
  // pipeline status
  input  wire logic                      store_queue_empty_i,
  input  wire logic                      complete_signalled_i,
  input  wire logic                      instr_completed_i,
  input  wire logic                      completion_fault_i,
  input  wire logic                      older_done_i,
  input  wire logic                      pipe_empty_i,
  input  wire logic                      instr_fetch_fault_i,
  input  wire logic                      instr_fault_i,
  // arbiter outputs
  output logic                           take_o,
  output epa_pkg::epa_exc_type           exc_class_o,
  output logic                           stop_dispatch_o,
  output logic                           halt_completion_o,
  output logic                           checkstop_o,
  output logic                           recoverable_o
);

  //////////////////////////////////////////////////////////////////////////////
  // source qualification

  logic       mc_cond;
  logic       dcnt_rise;
  logic       hard_rst;
  logic [4:0] mask_set;
  logic [4:0] mask_pend;
  logic [4:0] mask_clr;
  logic       soft_pend;
  logic       soft_clr;
  logic       soft_rise;
  logic       fetch_pend_reg;
  logic       instr_pend_reg;
  logic       trace_pend_reg;
  logic       next_done_reg;
  logic       take_next;
  epa_exc_type   class_next;
  epa_exc_type   class_reg;
  logic          take_reg;
  epa_state_type state_reg;
  logic          recov;
  logic          mask_any;

  assign hard_rst = hard_reset_in_i | test_reset_i;

  assign mc_cond = l1_addr_par_err_i | l1_data_par_err_i |
                   l2_data_par_err_i | transfer_error_ack_i |
                   machine_check_in_i;

  // msb zero to one on the down counter
  epa_edge u_dcnt_edge
  (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .level_i    (down_counter_i[`EPA_DCNT_WIDTH-1]),
    .rise_o     (dcnt_rise)
  );

  epa_edge u_soft_edge
  (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .level_i    (soft_reset_in_i),
    .rise_o     (soft_rise)
  );

  // perf and thermal arrive already selected by software
  // events latch regardless of enable; the enable gates taking them
  assign mask_set = {thermal_event_i, dcnt_rise, perf_mon_event_i,
                     ext_req_i, sys_mgmt_req_i};

  genvar gi;
  generate
    for (gi = 0; gi < `EPA_NUM_MASKABLE; gi++)
    begin : g_mask
      epa_sticky u_pend
      (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .set_i      (mask_set[gi]),
        .clr_i      (mask_clr[gi]),
        .pend_o     (mask_pend[gi])
      );
    end
  endgenerate

  epa_sticky u_soft
  (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .set_i      (soft_rise),
    .clr_i      (soft_clr),
    .pend_o     (soft_pend)
  );

  //////////////////////////////////////////////////////////////////////////////
  // recoverable state

  // drained store queue and signalled completion done
  // completion is the pipeline's retire-after-update pulse
  assign recov = recoverable_flag_i & store_queue_empty_i &
                 (~complete_signalled_i | instr_completed_i);

  // ext and others need async enable to be taken
  assign mask_any = async_enable_flag_i & (|mask_pend);

  // one instruction completes, then completion halts
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      next_done_reg <= 1'b0;
    else if (take_next || !mask_any)
      next_done_reg <= 1'b0;
    else if (instr_completed_i && !completion_fault_i)
      next_done_reg <= 1'b1;
  end

  assign halt_completion_o = next_done_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      fetch_pend_reg <= 1'b0;
    else if (instr_fetch_fault_i)
      fetch_pend_reg <= 1'b1;
    else if (take_next)
      fetch_pend_reg <= 1'b0;
  end

  assign stop_dispatch_o = fetch_pend_reg | instr_fetch_fault_i;

  // instruction fault waits for older completion
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      instr_pend_reg <= 1'b0;
    else if (instr_fault_i)
      instr_pend_reg <= 1'b1;
    else if (take_next)
      instr_pend_reg <= 1'b0;
  end

  // trace pending after a clean completion
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      trace_pend_reg <= 1'b0;
    else if (instr_completed_i && trace_enable_i && !completion_fault_i)
      trace_pend_reg <= 1'b1;
    else if (take_next)
      trace_pend_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // priority selection

  // no imprecise class is ever chosen
  always_comb
  begin
    class_next = EPA_EXC_NONE;
    mask_clr   = 5'h00;
    soft_clr   = 1'b0;
    if (hard_rst)
      class_next = EPA_EXC_HARD_RESET;
    else if (mc_cond && mcheck_enable_i && state_reg != EPA_ST_CHECKSTOP)
      class_next = EPA_EXC_MCHECK;
    else if (soft_pend && recov)
    begin
      class_next = EPA_EXC_SOFT_RESET;
      soft_clr   = 1'b1;
    end
    // completion fault wins and discards pending instruction fault
    else if (completion_fault_i)
      class_next = EPA_EXC_COMPLETION;
    else if (instr_pend_reg && older_done_i)
      class_next = EPA_EXC_INSTR;
    else if (fetch_pend_reg && pipe_empty_i && recov)
      class_next = EPA_EXC_FETCH;
    else if (trace_pend_reg)
      class_next = EPA_EXC_TRACE;
    else if (mask_any && next_done_reg && recov)
    begin
      if (mask_pend[0])
      begin
        class_next  = EPA_EXC_SYS_MGMT;
        mask_clr[0] = 1'b1;
      end
      else if (mask_pend[1])
      begin
        class_next  = EPA_EXC_EXT_REQ;
        mask_clr[1] = 1'b1;
      end
      else if (mask_pend[2])
      begin
        class_next  = EPA_EXC_PERF_MON;
        mask_clr[2] = 1'b1;
      end
      else if (mask_pend[3])
      begin
        class_next  = EPA_EXC_DECR;
        mask_clr[3] = 1'b1;
      end
      else
      begin
        class_next  = EPA_EXC_THERMAL;
        mask_clr[4] = 1'b1;
      end
    end
  end

  // checkstop blocks everything but hard reset
  assign take_next = (class_next != EPA_EXC_NONE) &&
                     (state_reg != EPA_ST_CHECKSTOP ||
                      class_next == EPA_EXC_HARD_RESET);

  //////////////////////////////////////////////////////////////////////////////
  // state and outputs

  // disabled machine check goes to checkstop
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      state_reg <= EPA_ST_RUN;
    else
      case (state_reg)
        EPA_ST_RUN:
          if (!hard_rst && mc_cond && !mcheck_enable_i)
            state_reg <= EPA_ST_CHECKSTOP;
          else if (fetch_pend_reg || instr_fetch_fault_i)
            state_reg <= EPA_ST_DRAIN;
        EPA_ST_DRAIN:
          if (!hard_rst && mc_cond && !mcheck_enable_i)
            state_reg <= EPA_ST_CHECKSTOP;
          else if (take_next)
            state_reg <= EPA_ST_RUN;
        EPA_ST_CHECKSTOP:
          if (hard_rst)
            state_reg <= EPA_ST_RUN;
        default:
          state_reg <= EPA_ST_RUN;
      endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      take_reg  <= 1'b0;
      class_reg <= EPA_EXC_NONE;
    end
    else
    begin
      take_reg  <= take_next;
      class_reg <= take_next ? class_next : EPA_EXC_NONE;
    end
  end

  assign take_o        = take_reg;
  assign exc_class_o   = class_reg;
  assign checkstop_o   = (state_reg == EPA_ST_CHECKSTOP);
  assign recoverable_o = recov;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_hard_first;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    hard_rst |=> take_o && exc_class_o == EPA_EXC_HARD_RESET;
  endproperty
  a_hard_first: assert property (p_hard_first)
    else $error("hard reset not taken next cycle");

  property p_mc_next;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !hard_rst && mc_cond && mcheck_enable_i && !checkstop_o
      |=> exc_class_o == EPA_EXC_MCHECK;
  endproperty
  a_mc_next: assert property (p_mc_next)
    else $error("machine check not taken");

  property p_checkstop;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !hard_rst && mc_cond && !mcheck_enable_i
      |=> checkstop_o && exc_class_o != EPA_EXC_MCHECK;
  endproperty
  a_checkstop: assert property (p_checkstop)
    else $error("disabled machine check did not checkstop");

  property p_soft_recov;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    exc_class_o == EPA_EXC_SOFT_RESET |-> $past(recov);
  endproperty
  a_soft_recov: assert property (p_soft_recov)
    else $error("soft reset taken while nonrecoverable");

  property p_mask_recov;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    take_o && exc_class_o inside {EPA_EXC_SYS_MGMT, EPA_EXC_EXT_REQ,
      EPA_EXC_PERF_MON, EPA_EXC_DECR, EPA_EXC_THERMAL}
      |-> $past(recov) && $past(async_enable_flag_i)
          && $past(next_done_reg);
  endproperty
  a_mask_recov: assert property (p_mask_recov)
    else $error("maskable taken without recoverable state");

  property p_ri_zero;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !recoverable_flag_i |-> !recoverable_o;
  endproperty
  a_ri_zero: assert property (p_ri_zero)
    else $error("recoverable with flag zero");

  // an external take must have had no system management pending
  property p_order;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    take_o && exc_class_o == EPA_EXC_EXT_REQ
      |-> !$past(mask_pend[0]);
  endproperty
  a_order: assert property (p_order)
    else $error("external taken ahead of system management");

  property p_instr_wait;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    exc_class_o == EPA_EXC_INSTR |-> $past(older_done_i);
  endproperty
  a_instr_wait: assert property (p_instr_wait)
    else $error("instruction fault taken before older completion");

  property p_compl_wins;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !hard_rst && !(mc_cond && mcheck_enable_i) && !(soft_pend && recov)
      && completion_fault_i && !checkstop_o
      |=> exc_class_o == EPA_EXC_COMPLETION;
  endproperty
  a_compl_wins: assert property (p_compl_wins)
    else $error("completion fault lost");

  property p_fetch_stop;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    instr_fetch_fault_i |=> stop_dispatch_o [*2];
  endproperty
  a_fetch_stop: assert property (p_fetch_stop)
    else $error("dispatch not stopped on fetch fault");

  c_hard:  cover property (@(posedge core_clk_i) take_o &&
                           exc_class_o == EPA_EXC_HARD_RESET);
  c_decr:  cover property (@(posedge core_clk_i) take_o &&
                           exc_class_o == EPA_EXC_DECR);
  c_stop:  cover property (@(posedge core_clk_i) checkstop_o);
  c_fetch: cover property (@(posedge core_clk_i) take_o &&
                           exc_class_o == EPA_EXC_FETCH);

endmodule

// ### epa_regs.svh
/*
 exception arbiter constants: priority slots, counts and widths.
 assumes inclusion by the arbiter package and modules only.
*/
`ifndef EPA_REGS_SVH
`define EPA_REGS_SVH

// asynchronous priority slots
`define EPA_PRIO_HARD_RESET   4'h0
`define EPA_PRIO_MCHECK       4'h1
`define EPA_PRIO_SOFT_RESET   4'h2
`define EPA_PRIO_SYS_MGMT     4'h3
`define EPA_PRIO_EXT_REQ      4'h4
`define EPA_PRIO_PERF_MON     4'h5
`define EPA_PRIO_DECR         4'h6
`define EPA_PRIO_THERMAL      4'h7

// number of maskable asynchronous sources
`define EPA_NUM_MASKABLE      5
// down counter width
`define EPA_DCNT_WIDTH        32
// machine check source count: l1 addr, l1 data, l2 data, tea, mcp
`define EPA_NUM_MC_SRC        5

`endif

// ### epa_pkg.sv
/*
 types shared by the exception arbiter.
 assumes epa_regs.svh is on the include path.
*/
`include "epa_regs.svh"

package epa_pkg;

  typedef enum logic [3:0]
  {
    EPA_EXC_NONE,
    EPA_EXC_HARD_RESET,
    EPA_EXC_MCHECK,
    EPA_EXC_SOFT_RESET,
    EPA_EXC_SYS_MGMT,
    EPA_EXC_EXT_REQ,
    EPA_EXC_PERF_MON,
    EPA_EXC_DECR,
    EPA_EXC_THERMAL,
    EPA_EXC_FETCH,
    EPA_EXC_INSTR,
    EPA_EXC_COMPLETION,
    EPA_EXC_TRACE
  } epa_exc_type;

  typedef enum logic [1:0]
  {
    EPA_ST_RUN,
    EPA_ST_DRAIN,
    EPA_ST_CHECKSTOP
  } epa_state_type;

endpackage

// ### epa_sticky.sv
/*
 sticky request latch: holds a request until taken.
 assumes set and take come from the same clock domain.
*/
module epa_sticky
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      pend_o
);

  logic pend_reg;

  // a new set in the clear cycle wins, so no event is lost
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      pend_reg <= 1'b0;
    else if (set_i)
      pend_reg <= 1'b1;
    else if (clr_i)
      pend_reg <= 1'b0;
  end

  assign pend_o = pend_reg;

endmodule

// ### epa_edge.sv
/*
 rising-edge detector on a synchronous level.
 assumes the input is already synchronous to core_clk_i.
*/
module epa_edge
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // level in, pulse out
  input  wire logic level_i,
  output logic      rise_o
);

  logic prev_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      prev_reg <= 1'b0;
    else
      prev_reg <= level_i;
  end

  assign rise_o = level_i & ~prev_reg;

endmodule

// ### epa_pipe_model.sv
/*
 behavioural pipeline completion model facing the exception arbiter.
 assumes the bench stalls the store queue and the arbiter halts or stops it.
*/
module epa_pipe_model
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // bench control and arbiter feedback
  input  wire logic sq_busy_i,
  input  wire logic halt_completion_i,
  input  wire logic stop_dispatch_i,
  // pipeline status
  output logic      store_queue_empty_o,
  output logic      complete_signalled_o,
  output logic      instr_completed_o,
  output logic      pipe_empty_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       phase_reg;
  logic [1:0] drain_reg;

  ////////////////////////////////////////////////////////////////////////////
  // signal then retire
  // a halted pipe signals nothing, so the arbiter can reach recoverable state
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || halt_completion_i)
      phase_reg <= 1'b0;
    else
      phase_reg <= ~phase_reg;
  end
  assign complete_signalled_o = ~phase_reg & ~halt_completion_i & ~sys_rst_i;
  assign instr_completed_o    = phase_reg;

  assign store_queue_empty_o = ~sq_busy_i;

  ////////////////////////////////////////////////////////////////////////////
  // stream drains slowly
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !stop_dispatch_i)
      drain_reg <= 2'h0;
    else if (drain_reg != 2'h3)
      drain_reg <= drain_reg + 2'h1;
  end
  assign pipe_empty_o = (drain_reg == 2'h3);
endmodule

// ### epa_arbiter_bench.sv
/*
 self-checking bench for the exception arbiter with a pipeline model.
 assumes epa_pkg and epa_regs.svh compiled first.
*/
`include "epa_regs.svh"

module epa_arbiter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import epa_pkg::*;

  logic                       core_clk_i, sys_rst_i;
  logic [1:0]                 rs;
  logic [4:0]                 mc;
  logic [7:0]                 ev;
  logic [`EPA_DCNT_WIDTH-1:0] dcnt;
  logic                       mc_en, async_en, recov, trace_en, older, sq_busy;
  logic                       sq_empty, signalled, completed, pipe_empty;
  logic                       take_o, stop_d, halt_c, cstop, recov_o;
  epa_exc_type                exc_class_o;
  logic                       last_halt;
  int                         fails, n_checks, k, n;

  epa_arbiter u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .hard_reset_in_i(rs[1]), .test_reset_i(rs[0]), .soft_reset_in_i(ev[0]),
    .l1_addr_par_err_i(mc[4]), .l1_data_par_err_i(mc[3]),
    .l2_data_par_err_i(mc[2]), .transfer_error_ack_i(mc[1]),
    .machine_check_in_i(mc[0]), .mcheck_enable_i(mc_en),
    .sys_mgmt_req_i(ev[7]), .ext_req_i(ev[6]), .perf_mon_event_i(ev[5]),
    .thermal_event_i(ev[4]), .down_counter_i(dcnt),
    .async_enable_flag_i(async_en), .recoverable_flag_i(recov),
    .trace_enable_i(trace_en), .store_queue_empty_i(sq_empty),
    .complete_signalled_i(signalled), .instr_completed_i(completed),
    .completion_fault_i(ev[3]), .older_done_i(older),
    .pipe_empty_i(pipe_empty), .instr_fetch_fault_i(ev[1]),
    .instr_fault_i(ev[2]), .take_o(take_o), .exc_class_o(exc_class_o),
    .stop_dispatch_o(stop_d), .halt_completion_o(halt_c),
    .checkstop_o(cstop), .recoverable_o(recov_o));

  epa_pipe_model u_pipe (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .sq_busy_i(sq_busy), .halt_completion_i(halt_c),
    .stop_dispatch_i(stop_d), .store_queue_empty_o(sq_empty),
    .complete_signalled_o(signalled), .instr_completed_o(completed),
    .pipe_empty_o(pipe_empty));

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic tick();
    @(posedge core_clk_i);
    #2;
  endtask

  // one-cycle event strobe; leading tick keeps strobes a cycle apart
  task automatic pulse(input logic [7:0] v);
    tick();
    ev = v;
    tick();
    ev = 8'h00;
  endtask

  task automatic wait_take(input epa_exc_type exp, input int lim);
    int i;
    for (i = 0; i < lim && take_o !== 1'b1; i++)
    begin
      last_halt = halt_c;
      tick();
    end
    chk("take", 4'h1, {3'h0, take_o});
    chk("class", exp, exc_class_o);
    tick();
    chk("take one shot", 4'h0, {3'h0, take_o});
    chk("class idle", EPA_EXC_NONE, exc_class_o);
  endtask

  task automatic no_take(input int cnt);
    repeat (cnt)
    begin
      tick();
      chk("no take", 4'h0, {3'h0, take_o});
    end
  endtask

  function automatic epa_exc_type mask_cls(input int idx);
    case (idx)
      0:       return EPA_EXC_SYS_MGMT;
      1:       return EPA_EXC_EXT_REQ;
      2:       return EPA_EXC_PERF_MON;
      3:       return EPA_EXC_DECR;
      default: return EPA_EXC_THERMAL;
    endcase
  endfunction

  function automatic logic [7:0] ev_of(input int idx);
    return (idx == 4) ? 8'h10 : (8'h80 >> idx);
  endfunction

  // msb of the down counter rises as it passes through zero
  task automatic dec_wrap();
    dcnt = 32'h00000000;
    tick();
    dcnt = 32'hFFFFFFFF;
  endtask

  initial
  begin
    #(40 * 20000);
    fails++;
    test_done();
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst_i = 1'b1; rs = 2'h0; mc = 5'h00; ev = 8'h00;
    dcnt = 32'h00001000; mc_en = 1'b1; async_en = 1'b1; recov = 1'b1;
    trace_en = 1'b0; older = 1'b0; sq_busy = 1'b0; last_halt = 1'b0;
    fails = 0; n_checks = 0;
    void'($urandom(32'hFE753906));
    repeat (20) tick();
    sys_rst_i = 1'b0;
    tick();
    recov = 1'b0;
    pulse(8'h01);
    for (k = 0; k < 2; k++)
    begin
      rs = 2'h2 >> k;
      tick();
      rs = 2'h0;
      wait_take(EPA_EXC_HARD_RESET, 3);
    end
    pulse(8'h01);
    for (k = 0; k < 5; k++)
    begin
      mc = 5'h10 >> k;
      tick();
      mc = 5'h00;
      wait_take(EPA_EXC_MCHECK, 3);
    end
    no_take(6);
    chk("recoverable", 4'h0, {3'h0, recov_o});
    recov = 1'b1;
    wait_take(EPA_EXC_SOFT_RESET, 10);
    mc_en = 1'b0;
    mc = 5'h01;
    tick();
    mc = 5'h00;
    no_take(6);
    chk("checkstop", 4'h1, {3'h0, cstop});
    rs = 2'h2;
    tick();
    rs = 2'h0;
    wait_take(EPA_EXC_HARD_RESET, 3);
    chk("checkstop left", 4'h0, {3'h0, cstop});
    mc_en = 1'b1;
    async_en = 1'b0;
    pulse(8'hF0);
    dec_wrap();
    no_take(8);
    async_en = 1'b1;
    for (k = 0; k < 5; k++)
    begin
      wait_take(mask_cls(k), 20);
      chk("halt before take", 4'h1, {3'h0, last_halt});
    end
    dcnt = 32'h00001000;
    sq_busy = 1'b1;
    pulse(8'h40);
    no_take(8);
    chk("recoverable", 4'h0, {3'h0, recov_o});
    sq_busy = 1'b0;
    wait_take(EPA_EXC_EXT_REQ, 20);
    pulse(8'h04);
    pulse(8'h08);
    wait_take(EPA_EXC_COMPLETION, 5);
    older = 1'b1;
    no_take(6);
    pulse(8'h04);
    wait_take(EPA_EXC_INSTR, 5);
    older = 1'b0;
    pulse(8'h02);
    chk("stop dispatch", 4'h1, {3'h0, stop_d});
    wait_take(EPA_EXC_FETCH, 12);
    chk("dispatch resumes", 4'h0, {3'h0, stop_d});
    trace_en = 1'b1;
    wait_take(EPA_EXC_TRACE, 10);
    trace_en = 1'b0;
    repeat (6) tick();
    for (n = 0; n < 24; n++)
    begin
      k = $urandom % 5;
      async_en = 1'b0;
      if (k == 3)
        dec_wrap();
      else
        pulse(ev_of(k));
      repeat ($urandom % 4) tick();
      async_en = 1'b1;
      wait_take(mask_cls(k), 20);
      dcnt = $urandom & 32'h7FFFFFFF;
    end
    test_done();
  end
endmodule
